/* File: led_fault_pkg.sv */
// Constants and carrier types for the LED fault supervision block
package led_fault_pkg;

  // ----------------------------------------------------------------
  // Channel and sampling figures
  // ----------------------------------------------------------------
  localparam int CH_COUNT = 16;
  localparam int GRAY_W = 16;
  localparam int SAMPLE_EDGE = 33;
  localparam logic [GRAY_W-1:0] GRAY_MIN_VALID = 16'h1001;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] LIVE_OFS = 4'hC;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAGS_OT_POS = 16;
  localparam int IRQ_OPEN_POS = 0;
  localparam int IRQ_OT_SET_POS = 1;
  localparam int IRQ_OT_CLR_POS = 2;
  localparam int IRQ_W = 3;
  localparam int LIVE_BLANK_POS = 0;
  localparam int LIVE_CUTOFF_POS = 1;
  localparam int LIVE_COOL_POS = 2;
  localparam int LIVE_OTOFF_POS = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [CH_COUNT-1:0] OPEN_FLAG_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic overtemperature_flag;
    logic [CH_COUNT-1:0] open_led_flag;
  } status_word_type;

  typedef struct packed {
    logic ot_clear;
    logic ot_set;
    logic open_found;
  } irq_bits_type;

  typedef enum logic [2:0] {
    OT_IDLE = 3'b001,
    OT_WAIT_SHIFT = 3'b010,
    OT_DONE = 3'b100
  } ot_eval_type;

endpackage

/* File: pin_sync_edge.sv */
// Two-stage pin synchroniser with edge pulses
`timescale 1ns/10ps
module pin_sync_edge #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pins
  input wire logic [WIDTH-1:0] pin_in,
  // Synchronised level and edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] prev_r;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync_edge: WIDTH must be at least 1");
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser chain; meta_r feeds level only
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      level <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      level <= meta_r;
      prev_r <= level;
    end
  end

  // Edge pulses from the settled stages
  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule

/* File: led_fault_ctrl.sv */
// Open-LED detection, auto output off and thermal cutoff supervision
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
//
// Contract
// - Sample lit channels at 33rd grayscale edge
// - Low output voltage sets channel open flag
// - Error output asserts as open flag sets
// - Flagged channel forced off at sampling
// - Forced channel resumes after next blank fall
// - Open flags hold until next sampling
// - Gray level below 1001h never flags
// - Open errors float output while blanked
// - Cutoff kills all channels, sets flag
// - Error output low with flag set
// - Flag held until shift after latch
// - Re-evaluate flag at that shift edge
// - Overtemp error stays driven while blanked
// - Outputs resume if cool at blank rise
// - All channels off while blanked
// - Status loads on shift rise after latch
module led_fault_ctrl
  import led_fault_pkg::*;
#(
  parameter int NUM_CH = CH_COUNT,
  parameter int SAMPLE_AT = SAMPLE_EDGE
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Display controller pins
  input wire logic blank,
  input wire logic latch_strobe,
  input wire logic shift_clock,
  input wire logic grayscale_clock,
  input wire logic bc_select,
  // Analog sensing
  input wire logic [NUM_CH-1:0] open_short_cmp,
  input wire logic thermal_cutoff,
  input wire logic thermal_cool,
  // PWM core (same clock)
  input wire logic [NUM_CH*GRAY_W-1:0] gray_level,
  input wire logic [NUM_CH-1:0] pwm_on,
  // Driver and status outputs
  output logic [NUM_CH-1:0] sink_channel,
  output logic error_output_o,
  output logic error_output_oe,
  output logic status_load,
  output status_word_type status_readback
);

  initial begin
    if (NUM_CH != CH_COUNT) begin
      $error("led_fault_ctrl: NUM_CH must equal the status word width");
    end
    if (SAMPLE_AT < 1 || SAMPLE_AT > 63) begin
      $error("led_fault_ctrl: SAMPLE_AT out of range");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;
  logic [NUM_CH-1:0] cmp_s;

  pin_sync_edge #(.WIDTH(NPIN)) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({thermal_cool, thermal_cutoff, bc_select, grayscale_clock,
             shift_clock, latch_strobe, blank}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  pin_sync_edge #(.WIDTH(NUM_CH)) u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(open_short_cmp),
    .level(cmp_s),
    .rise(),
    .fall()
  );

  logic blank_s;
  logic blank_rise;
  logic blank_fall;
  logic latch_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic grayscale_clock_rise;
  logic bc_sel_s;
  logic cutoff_s;
  logic cool_s;

  assign blank_s = pin_lvl[0];
  assign blank_rise = pin_rise[0];
  assign blank_fall = pin_fall[0];
  assign latch_fall = pin_fall[1];
  assign sclk_rise = pin_rise[2];
  assign sclk_fall = pin_fall[2];
  assign grayscale_clock_rise = pin_rise[3];
  assign bc_sel_s = pin_lvl[4];
  assign cutoff_s = pin_lvl[5];
  assign cool_s = pin_lvl[6];

  // ----------------------------------------------------------------
  // Gray level qualification
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] gray_ok;

  // Channels below the minimum valid level never flag
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_gray
      assign gray_ok[gi] = gray_level[gi*GRAY_W +: GRAY_W] >= GRAY_MIN_VALID;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Display period tracking and sampling edge
  // ----------------------------------------------------------------
  logic armed_r;
  logic [5:0] gs_cnt_r;
  logic sample_evt;
  logic [NUM_CH-1:0] new_flags;
  localparam logic [5:0] LAST_CNT = 6'(SAMPLE_AT - 1);

  // Arm on blank release, disarm after the sampling edge or on blank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
      gs_cnt_r <= 6'h00;
    end else if (blank_fall) begin
      armed_r <= 1'b1;
      gs_cnt_r <= 6'h00;
    end else if (blank_s || sample_evt) begin
      armed_r <= 1'b0;
    end else if (armed_r && grayscale_clock_rise) begin
      gs_cnt_r <= gs_cnt_r + 6'h01;
    end
  end

  // Sampling edge and the flags it produces
  assign sample_evt = armed_r && grayscale_clock_rise && !blank_s && gs_cnt_r == LAST_CNT;
  assign new_flags = pwm_on & gray_ok & cmp_s;

  // ----------------------------------------------------------------
  // Open flags and auto output off
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] open_flag_r;
  logic [NUM_CH-1:0] forced_off_r;
  logic rel_pend_r;

  // Flags replaced only at the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_flag_r <= OPEN_FLAG_RST;
    end else if (sample_evt) begin
      open_flag_r <= new_flags;
    end
  end

  // Release pending from blank fall until next grayscale edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_pend_r <= 1'b0;
    end else if (blank_fall) begin
      rel_pend_r <= 1'b1;
    end else if (grayscale_clock_rise) begin
      rel_pend_r <= 1'b0;
    end
  end

  // Faulty channels off until resumed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_off_r <= '0;
    end else if (sample_evt) begin
      forced_off_r <= forced_off_r | new_flags;
    end else if (rel_pend_r && grayscale_clock_rise) begin
      forced_off_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Overtemperature flag, cutoff and recovery
  // ----------------------------------------------------------------
  logic ot_flag_r;
  logic ot_off_r;
  logic cool_at_blank_r;
  ot_eval_type ot_state_r;
  logic ot_eval;
  logic ot_clear_evt;

  assign ot_eval = ot_state_r == OT_WAIT_SHIFT && sclk_fall;
  assign ot_clear_evt = ot_eval && !cutoff_s && cool_s && ot_flag_r;

  // Wait for the shift edge after a grayscale latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_state_r <= OT_IDLE;
    end else begin
      case (ot_state_r)
        OT_IDLE: begin
          if (latch_fall && !bc_sel_s) begin
            ot_state_r <= OT_WAIT_SHIFT;
          end
        end
        OT_WAIT_SHIFT: begin
          if (sclk_fall) begin
            ot_state_r <= OT_DONE;
          end
        end
        OT_DONE: begin
          ot_state_r <= OT_IDLE;
        end
        default: begin
          ot_state_r <= OT_IDLE;
        end
      endcase
    end
  end

  // Flag set wins; cleared only at the re-evaluation edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_flag_r <= 1'b0;
    end else if (cutoff_s) begin
      ot_flag_r <= 1'b1;
    end else if (ot_clear_evt) begin
      ot_flag_r <= 1'b0;
    end
  end

  // Temperature state seen at blank rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cool_at_blank_r <= 1'b0;
    end else if (blank_rise) begin
      cool_at_blank_r <= cool_s && !cutoff_s;
    end
  end

  // Outputs held off until a cool blank cycle completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_off_r <= 1'b0;
    end else if (cutoff_s) begin
      ot_off_r <= 1'b1;
    end else if (rel_pend_r && grayscale_clock_rise && cool_at_blank_r) begin
      ot_off_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sink gating and error pin
  // ----------------------------------------------------------------
  logic open_any;

  assign open_any = (|open_flag_r) || (sample_evt && |new_flags);
  assign sink_channel = (blank_s || cutoff_s || ot_off_r) ? '0 :
                        pwm_on & ~forced_off_r & ~(sample_evt ? new_flags : '0);
  assign error_output_o = 1'b0;
  assign error_output_oe = ot_flag_r || cutoff_s || (open_any && !blank_s);

  // ----------------------------------------------------------------
  // Status readback load
  // ----------------------------------------------------------------
  logic sid_pend_r;

  // Load on first shift rise after a latch fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sid_pend_r <= 1'b0;
      status_load <= 1'b0;
      status_readback <= '0;
    end else begin
      status_load <= 1'b0;
      if (latch_fall) begin
        sid_pend_r <= 1'b1;
      end else if (sid_pend_r && sclk_rise) begin
        sid_pend_r <= 1'b0;
        status_load <= 1'b1;
        status_readback <= '{overtemperature_flag: ot_flag_r, open_led_flag: open_flag_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // APB registers and interrupt
  // ----------------------------------------------------------------
  irq_bits_type irq_stat_r;
  irq_bits_type irq_evt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic setup_ph;
  logic access_ph;

  function automatic logic [1:0] reg_idx(input logic [ADDR_W-1:0] a);
    case (a)
      FLAGS_OFS: reg_idx = 2'd0;
      IRQ_STAT_OFS: reg_idx = 2'd1;
      IRQ_MASK_OFS: reg_idx = 2'd2;
      default: reg_idx = 2'd3;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = a == FLAGS_OFS || a == IRQ_STAT_OFS || a == IRQ_MASK_OFS || a == LIVE_OFS;
  endfunction

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph;
  assign pslverr = access_ph && !reg_hit(paddr);
  assign irq_evt = '{ot_clear: ot_clear_evt, ot_set: cutoff_s && !ot_flag_r,
                     open_found: sample_evt && |new_flags};
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data captured in setup for a registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      case (reg_idx(paddr))
        2'd0: prdata <= {15'h0000, ot_flag_r, open_flag_r};
        2'd1: prdata <= {29'h0000_0000, irq_stat_r};
        2'd2: prdata <= {29'h0000_0000, irq_mask_r};
        default: prdata <= (paddr == LIVE_OFS) ?
          {28'h000_0000, ot_off_r, cool_s, cutoff_s, blank_s} : 32'h0000_0000;
      endcase
    end
  end

  // Mask register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (access_ph && pwrite && paddr == IRQ_MASK_OFS) begin
      irq_mask_r <= pwdata[IRQ_W-1:0];
    end
  end

  // Sticky status, cleared by read, new events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else if (access_ph && !pwrite && paddr == IRQ_STAT_OFS) begin
      // Only bits already reported in prdata are cleared
      irq_stat_r <= irq_evt | (irq_stat_r & ~prdata[IRQ_W-1:0]);
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sample_flags_a: assert property (sample_evt |=> open_flag_r == $past(new_flags))
    else $error("open flags not loaded at sampling edge");
  sample_count_a: assert property (sample_evt |-> gs_cnt_r == LAST_CNT && armed_r)
    else $error("sampling edge at wrong count");
  flags_hold_a: assert property (!sample_evt |=> $stable(open_flag_r))
    else $error("open flags changed outside sampling");
  low_gray_a: assert property (sample_evt |=> (open_flag_r & ~$past(gray_ok)) == '0)
    else $error("flag set for low gray level");
  err_open_a: assert property (sample_evt && |new_flags && !blank_s |-> error_output_oe)
    else $error("error pin late on open detection");
  forced_off_a: assert property (sample_evt |-> ##[0:1] (sink_channel & new_flags) == '0)
    else $error("flagged channel still sinking");
  blank_off_a: assert property (blank_s |-> sink_channel == '0)
    else $error("channel on while blanked");
  open_float_a: assert property (blank_s && !ot_flag_r && !cutoff_s |-> !error_output_oe)
    else $error("open error driven while blanked");
  cutoff_off_a: assert property (cutoff_s |-> sink_channel == '0 && error_output_oe)
    else $error("cutoff not immediate");
  ot_hold_a: assert property (ot_flag_r && !ot_eval |=> ot_flag_r)
    else $error("overtemp flag dropped early");
  ot_blank_a: assert property (ot_flag_r && blank_s |-> error_output_oe)
    else $error("overtemp error floated while blanked");
  sid_load_a: assert property (sid_pend_r && sclk_rise && !latch_fall |=> status_load)
    else $error("status not loaded on shift edge");

endmodule

/* File: disp_ctrl_model.sv */
// Display controller model driving the timing pins of the fault block
`timescale 1ns/10ps
module disp_ctrl_model (
  // Clock
  input wire logic pclk,
  // Timing pins
  output logic blank,
  output logic latch_strobe,
  output logic shift_clock,
  output logic grayscale_clock,
  output logic bc_select
);
  // Power on blanked, clocks idle low
  initial begin
    blank = 1'b1;
    latch_strobe = 1'b0;
    shift_clock = 1'b0;
    grayscale_clock = 1'b0;
    bc_select = 1'b0;
  end

  // Wait a number of pclk edges
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Grayscale burst, 400 ns period, idle low between bursts
  task automatic gs(input int n);
    repeat (n) begin
      grayscale_clock <= 1'b1;
      hold(4);
      grayscale_clock <= 1'b0;
      hold(4);
    end
  endtask

  // Latch pulse; bc high selects brightness data
  task automatic latch(input logic bc);
    bc_select <= bc;
    latch_strobe <= 1'b1;
    hold(4);
    latch_strobe <= 1'b0;
    hold(4);
  endtask

  // One shift clock pulse, rise then fall
  task automatic shift();
    shift_clock <= 1'b1;
    hold(4);
    shift_clock <= 1'b0;
    hold(4);
  endtask

  // Move the blank pin and let the synchroniser settle
  task automatic set_blank(input logic v);
    blank <= v;
    hold(6);
  endtask

  // Start-up: one latch pulse and one blank rising edge
  task automatic power_up();
    latch(1'b0);
    set_blank(1'b0);
    set_blank(1'b1);
  endtask
endmodule

/* File: tb_led_fault_ctrl.sv */
// Self-checking bench for the LED fault supervision block
`timescale 1ns/10ps
module tb_led_fault_ctrl;
  import led_fault_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic blank;
  logic latch_strobe;
  logic shift_clock;
  logic grayscale_clock;
  logic bc_select;
  logic [CH_COUNT-1:0] open_short_cmp = '0;
  logic thermal_cutoff = 1'b0;
  logic thermal_cool = 1'b1;
  logic [CH_COUNT*GRAY_W-1:0] gray_level = '0;
  logic [CH_COUNT-1:0] pwm_on = '0;
  logic [CH_COUNT-1:0] sink_channel;
  logic error_output_o;
  logic error_output_oe;
  logic status_load;
  status_word_type status_readback;
  int err_count = 0;
  int n_checks = 0;

  // 20 MHz clock
  always #25 pclk = ~pclk;

  led_fault_ctrl led_fault_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .blank(blank),
    .latch_strobe(latch_strobe), .shift_clock(shift_clock),
    .grayscale_clock(grayscale_clock), .bc_select(bc_select),
    .open_short_cmp(open_short_cmp), .thermal_cutoff(thermal_cutoff),
    .thermal_cool(thermal_cool), .gray_level(gray_level), .pwm_on(pwm_on),
    .sink_channel(sink_channel), .error_output_o(error_output_o),
    .error_output_oe(error_output_oe), .status_load(status_load),
    .status_readback(status_readback));

  disp_ctrl_model disp_ctrl_model_inst (.pclk(pclk), .blank(blank),
    .latch_strobe(latch_strobe), .shift_clock(shift_clock),
    .grayscale_clock(grayscale_clock), .bc_select(bc_select));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      err_count++;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string w);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(w, rd, exp);
  endtask

  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values and an unmapped address
  task automatic reset_regs();
    logic [31:0] rd;
    logic e;
    rd_chk(IRQ_MASK_OFS, 32'h0, "mask reset");
    rd_chk(FLAGS_OFS, 32'h0, "flags reset");
    apb(1'b0, 4'h1, 32'h0, rd, e);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask

  // Open LED sampling, auto off and recovery
  task automatic open_led();
    gray_level <= {208'h0, 48'h100110001001};
    open_short_cmp <= 16'h0003;
    pwm_on <= 16'hFFFF;
    wr(IRQ_MASK_OFS, 32'h7);
    disp_ctrl_model_inst.set_blank(1'b0);
    disp_ctrl_model_inst.gs(SAMPLE_EDGE - 1);
    rd_chk(FLAGS_OFS, 32'h0, "flags before edge");
    chk("sinks lit", 32'(sink_channel), 32'hFFFF);
    disp_ctrl_model_inst.gs(1);
    rd_chk(FLAGS_OFS, 32'h1, "open flags");
    chk("oe open", 32'(error_output_oe), 32'h1);
    chk("sink forced", 32'(sink_channel), 32'hFFFE);
    chk("irq open", 32'(irq), 32'h1);
    rd_chk(IRQ_STAT_OFS, 32'h1, "stat open");
    chk("irq cleared", 32'(irq), 32'h0);
    disp_ctrl_model_inst.set_blank(1'b1);
    chk("oe blanked", 32'(error_output_oe), 32'h0);
    chk("sinks blanked", 32'(sink_channel), 32'h0);
    disp_ctrl_model_inst.latch(1'b0);
    disp_ctrl_model_inst.shift();
    chk("readback", 32'(status_readback), 32'h1);
    disp_ctrl_model_inst.set_blank(1'b0);
    disp_ctrl_model_inst.gs(1);
    chk("sink back", 32'(sink_channel), 32'hFFFF);
    rd_chk(FLAGS_OFS, 32'h1, "flags held");
    chk("oe unblanked", 32'(error_output_oe), 32'h1);
  endtask

  // Thermal cutoff, hold, clear and restart
  task automatic overtemp();
    wr(IRQ_MASK_OFS, 32'h1);
    thermal_cutoff <= 1'b1;
    thermal_cool <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("sinks cutoff", 32'(sink_channel), 32'h0);
    chk("oe cutoff", 32'(error_output_oe), 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    rd_chk(FLAGS_OFS, 32'h10001, "ot flag");
    thermal_cutoff <= 1'b0;
    thermal_cool <= 1'b1;
    repeat (5) @(posedge pclk);
    rd_chk(FLAGS_OFS, 32'h10001, "ot held");
    disp_ctrl_model_inst.set_blank(1'b1);
    chk("oe ot blanked", 32'(error_output_oe), 32'h1);
    disp_ctrl_model_inst.latch(1'b1);
    disp_ctrl_model_inst.shift();
    rd_chk(FLAGS_OFS, 32'h10001, "ot held bc latch");
    disp_ctrl_model_inst.latch(1'b0);
    chk("oe after latch", 32'(error_output_oe), 32'h1);
    disp_ctrl_model_inst.shift();
    chk("readback ot", 32'(status_readback), 32'h10001);
    rd_chk(FLAGS_OFS, 32'h1, "ot cleared");
    chk("oe floated", 32'(error_output_oe), 32'h0);
    wr(IRQ_MASK_OFS, 32'h7);
    chk("irq unmasked", 32'(irq), 32'h1);
    rd_chk(IRQ_STAT_OFS, 32'h6, "stat ot");
    chk("irq ot cleared", 32'(irq), 32'h0);
    disp_ctrl_model_inst.set_blank(1'b0);
    chk("sinks wait", 32'(sink_channel), 32'h0);
    disp_ctrl_model_inst.gs(1);
    chk("sinks resume", 32'(sink_channel), 32'hFFFF);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    disp_ctrl_model_inst.power_up();
    reset_regs();
    open_led();
    overtemp();
    finish_test();
  end

  // Cut a hang short after 20000 cycles
  initial begin
    #(20000 * 50);
    err_count++;
    finish_test();
  end
endmodule
